// ### rtl/sffr_consts.vh
// Constants for the sensor fault flag reporting block.
`ifndef SFFR_CONSTS_VH
`define SFFR_CONSTS_VH
`define SFFR_ADDR_W 8
`define SFFR_DATA_W 26
`define SFFR_OFS_INFO 8'h0c
`define SFFR_OFS_FAULT 8'h0f
`define SFFR_OFS_MARGIN 8'h85
`define SFFR_OFS_PINCOMM 8'ha5
`define SFFR_OFS_SUPPLY 8'ha9
`define SFFR_OFS_TRISEL 8'h24
`define SFFR_OFS_RATE 8'h25
`define SFFR_OFS_PORCH 8'h3f
`define SFFR_MARGIN_TRIG_BIT 0
`define SFFR_MARGIN_REPEAT_BIT 13
`define SFFR_BIDIR_EN_BIT 15
`define SFFR_SUPPLY_TRIG_BIT 0
`define SFFR_SUPPLY_ACTIVE_BIT 1
`define SFFR_TRISEL_BIT 15
`define SFFR_RATE_HI 7
`define SFFR_RATE_LO 3
`define SFFR_PORCH_HI 13
`define SFFR_PORCH_LO 11
`define SFFR_INFO_READY_BIT 0
`define SFFR_INFO_MASK_BIT 6
`define SFFR_INFO_SUPPLY_FAIL_BIT 7
`define SFFR_INFO_CORR_FAIL_BIT 9
`define SFFR_F_VCF 0
`define SFFR_F_TSE 1
`define SFFR_F_SAT 2
`define SFFR_F_OSC 3
`define SFFR_F_CHM 4
`define SFFR_F_WEAK 5
`define SFFR_F_STRONG 6
`define SFFR_F_UNDER 7
`define SFFR_F_OVER 8
`define SFFR_F_POR 9
`define SFFR_F_SBE 10
`define SFFR_F_MBE 11
`define SFFR_F_SHADOW 12
`define SFFR_F_BUSY 13
`define SFFR_F_EXEC 14
`define SFFR_F_IFACE 15
`define SFFR_RESET_ONLY_MASK 16'h1808
`define SFFR_FAULT_RESET 16'h0200
`define SFFR_CLK_MHZ 25
`define SFFR_TICK_NS 1000
`define SFFR_TICK_CYC ((`SFFR_TICK_NS * `SFFR_CLK_MHZ) / 1000)
`define SFFR_DUTY_STEPS 8'd200
`define SFFR_HIZ_PERIODS 2'd2
`endif

// ### rtl/sffr_fault_prio.v
// Priority encoder that picks the fault code and its error duty cycle.
`timescale 1ns/1ps
`include "sffr_consts.vh"
module sffr_fault_prio (
	input wire [15:0] i_flags,
	input wire [2:0] i_porch_sel,
	output reg o_any,
	output reg o_top_hiz,
	output reg [7:0] o_duty
);
	// Duty in steps of 200; porch select only trims the power-on code at setting seven, a simplification.
	function [7:0] sffr_duty;
		input [3:0] code;
		input [2:0] porch;
		begin
			case (code)
				4'h1: sffr_duty = 8'd33;
				4'h2: sffr_duty = 8'd78;
				4'h3: sffr_duty = 8'd66;
				4'h4: sffr_duty = 8'd145;
				4'h5: sffr_duty = 8'd134;
				4'h6: sffr_duty = 8'd122;
				4'h7: sffr_duty = 8'd113;
				4'h8: sffr_duty = 8'd89;
				4'h9: sffr_duty = 8'd44;
				4'ha: sffr_duty = 8'd156;
				default: sffr_duty = 8'd0;
			endcase
			if (porch == 3'h7 && code == 4'h1) begin
				sffr_duty = 8'd30;
			end
		end
	endfunction
	reg [3:0] code;
	always @* begin
		code = 4'h0;
		o_any = |i_flags;
		o_top_hiz = i_flags[`SFFR_F_OSC] | i_flags[`SFFR_F_SHADOW] | i_flags[`SFFR_F_MBE]; // RULE20
		if (i_flags[`SFFR_F_POR]) begin // RULE19
			code = 4'h1;
		end else if (i_flags[`SFFR_F_UNDER]) begin
			code = 4'h2;
		end else if (i_flags[`SFFR_F_VCF]) begin
			code = 4'h3;
		end else if (i_flags[`SFFR_F_OVER]) begin
			code = 4'h4;
		end else if (i_flags[`SFFR_F_TSE]) begin
			code = 4'h5;
		end else if (i_flags[`SFFR_F_STRONG]) begin
			code = 4'h6;
		end else if (i_flags[`SFFR_F_SAT]) begin
			code = 4'h7;
		end else if (i_flags[`SFFR_F_WEAK]) begin
			code = 4'h8;
		end else if (i_flags[`SFFR_F_CHM]) begin
			code = 4'h9;
		end else if (i_flags[`SFFR_F_SBE]) begin
			code = 4'ha;
		end
		o_duty = o_top_hiz ? `SFFR_DUTY_STEPS : sffr_duty(code, i_porch_sel); // RULE21
	end
endmodule // sffr_fault_prio

// ### rtl/sffr_pwm_out.v
// PWM generator with error duty, half-rate error carrier and tristate hold.
`timescale 1ns/1ps
`include "sffr_consts.vh"
module sffr_pwm_out (
	input wire i_clk_sys,
	input wire i_rstn,
	input wire i_stop,
	input wire i_fault,
	input wire i_tristate_sel,
	input wire i_top_hiz,
	input wire [7:0] i_fault_duty,
	input wire [7:0] i_angle_duty,
	input wire [4:0] i_rate,
	output reg o_pwm,
	output reg o_pwm_oe
);
	reg [15:0] tick_reg;
	reg [7:0] step_reg;
	reg [1:0] hiz_reg;
	wire [15:0] tick_max = {11'h0, i_rate} + 16'h1;
	// Error carrier runs at half the frequency, so each step lasts twice as long.
	wire [15:0] tick_lim = (i_fault && !i_tristate_sel) ? {tick_max[14:0], 1'b0} : tick_max; // RULE18
	wire tick_end = tick_reg >= tick_lim - 16'h1;
	wire period_end = tick_end && (step_reg == `SFFR_DUTY_STEPS - 8'd1);
	wire [7:0] duty = i_fault ? i_fault_duty : i_angle_duty; // RULE24
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tick_reg <= 16'h0;
			step_reg <= 8'h0;
			hiz_reg <= 2'h0;
			o_pwm <= 1'b0;
			o_pwm_oe <= 1'b0;
		end else begin
			tick_reg <= tick_end ? 16'h0 : tick_reg + 16'h1;
			if (tick_end) begin
				step_reg <= (step_reg == `SFFR_DUTY_STEPS - 8'd1) ? 8'h0 : step_reg + 8'h1;
			end
			if (i_fault && i_tristate_sel) begin
				hiz_reg <= `SFFR_HIZ_PERIODS; // RULE17
			end else if (period_end && hiz_reg != 2'h0) begin
				hiz_reg <= hiz_reg - 2'h1;
			end
			o_pwm <= step_reg < duty;
			if (i_stop) begin
				o_pwm_oe <= 1'b0; // RULE4
			end else if ((i_fault && i_tristate_sel) || hiz_reg != 2'h0) begin
				o_pwm_oe <= 1'b0; // RULE17
			end else if (i_fault && i_top_hiz) begin
				o_pwm_oe <= 1'b0; // RULE20
			end else begin
				o_pwm_oe <= 1'b1;
			end
		end
	end
endmodule // sffr_pwm_out

// ### rtl/sffr_top.v
// Fault flag collection, register access and PWM fault reporting.
// Behaviour
// RULE1: Writing one to margin trigger bit starts the memory margin test.
// RULE2: Single run clears trigger on completion; repeat mode runs until trigger cleared.
// RULE3: A margin test error clears the trigger, stopping repeat runs.
// RULE4: Bidirectional enable stops PWM and frees the pin for Manchester use.
// RULE5: Enable set by write or access code; host leaves by writing zero.
// RULE6: Supply-check trigger runs self-test; failure shows in info bit seven.
// RULE7: Supply-check active bit reads one only while the self-test runs.
// RULE8: All fault flags readable in fault register through SPI and Manchester.
// RULE9: Fault flags stay set until read or reset and condition gone.
// RULE10: Each frame error bit is the OR of fault register bits.
// RULE11: Frame error bits clear only after SPI read and condition gone.
// RULE12: After reset both frame error bits read one.
// RULE13: Masked fault flags are left out of frame error bits.
// RULE14: Fault bits zero to six hold the first seven fault causes.
// RULE15: Fault bits seven to fifteen hold supply, memory and interface faults.
// RULE16: Info register holds ready, mask, supply fail and correction fail flags.
// RULE17: Tristate select makes any fault float PWM at least two periods.
// RULE18: Duty reporting uses fault duty at half the programmed PWM rate.
// RULE19: Several faults report the duty of the highest priority one.
// RULE20: Oscillator, shadow and uncorrectable faults report as high impedance.
// RULE21: Porch select sets PWM limits and fault duty cycles; code sets no limits, trims only power-on duty at seven.
// RULE22: Oscillator, shadow and uncorrectable flags clear only on reset.
// RULE23: A persisting cause keeps its flag set across reads.
// RULE24: With no faults, PWM returns to angle proportional duty.
`timescale 1ns/1ps
`include "sffr_consts.vh"
module sffr_top (
	input wire i_clk_sys,
	input wire i_rstn,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire i_reg_spi,
	input wire [7:0] i_reg_addr,
	input wire [25:0] i_reg_wdata,
	output reg [25:0] o_reg_rdata,
	input wire i_access_code,
	input wire [15:0] i_fault_cond,
	input wire [15:0] i_fault_mask,
	input wire i_angle_sample_ready,
	input wire i_correction_selftest_failed,
	input wire i_margin_done,
	input wire i_margin_error,
	input wire i_supply_check_done,
	input wire i_supply_check_fail,
	input wire [7:0] i_angle_duty,
	output wire o_margin_run,
	output wire o_supply_check_run,
	output wire o_bidir_pin_comm_enable,
	output reg o_frame_error_bit_zero,
	output reg o_frame_error_bit_one,
	output wire o_pwm,
	output wire o_pwm_oe
);
	reg [15:0] cond_s1_reg;
	reg [15:0] cond_s2_reg;
	reg [15:0] fault_reg;
	reg [15:0] fault_next;
	reg margin_trig_reg;
	reg margin_repeat_reg;
	reg bidir_reg;
	reg supply_trig_reg;
	reg supply_active_reg;
	reg supply_fail_reg;
	reg tristate_sel_reg;
	reg [4:0] rate_reg;
	reg [2:0] porch_reg;
	reg frame_hold_reg;
	wire fault_rd = i_reg_rd && (i_reg_addr == `SFFR_OFS_FAULT);
	wire [15:0] unmasked = fault_reg & ~i_fault_mask;
	wire any_fault;
	wire top_hiz;
	wire [7:0] fault_duty;
	// Fault causes come from other logic on slower paths, so they are synchronised first.
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cond_s1_reg <= 16'h0;
			cond_s2_reg <= 16'h0;
		end else begin
			cond_s1_reg <= i_fault_cond;
			cond_s2_reg <= cond_s1_reg;
		end
	end
	always @* begin
		fault_next = fault_reg | cond_s2_reg; // RULE14 RULE15
		if (fault_rd) begin
			// Set wins over clear: a live cause survives the read.
			fault_next = (fault_reg & `SFFR_RESET_ONLY_MASK) | cond_s2_reg; // RULE9 RULE22 RULE23
		end
	end
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			fault_reg <= `SFFR_FAULT_RESET;
			frame_hold_reg <= 1'b1;
			o_frame_error_bit_zero <= 1'b1; // RULE12
			o_frame_error_bit_one <= 1'b1;
		end else begin
			fault_reg <= fault_next;
			if (fault_rd && i_reg_spi) begin
				frame_hold_reg <= 1'b0;
			end
			// Status bits only fall after an SPI read; a Manchester read leaves them high.
			if (fault_rd && i_reg_spi) begin
				o_frame_error_bit_zero <= |(fault_next & ~i_fault_mask); // RULE11 RULE13
				o_frame_error_bit_one <= |(fault_next & ~i_fault_mask);
			end else begin
				o_frame_error_bit_zero <= frame_hold_reg | o_frame_error_bit_zero | (|unmasked); // RULE10
				o_frame_error_bit_one <= frame_hold_reg | o_frame_error_bit_one | (|unmasked);
			end
		end
	end
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			margin_trig_reg <= 1'b0;
			margin_repeat_reg <= 1'b0;
			bidir_reg <= 1'b0;
			supply_trig_reg <= 1'b0;
			supply_active_reg <= 1'b0;
			supply_fail_reg <= 1'b0;
			tristate_sel_reg <= 1'b0;
			rate_reg <= 5'h0;
			porch_reg <= 3'h0;
		end else begin
			if (i_reg_wr && i_reg_addr == `SFFR_OFS_MARGIN) begin
				margin_trig_reg <= i_reg_wdata[`SFFR_MARGIN_TRIG_BIT]; // RULE1
				margin_repeat_reg <= i_reg_wdata[`SFFR_MARGIN_REPEAT_BIT];
			end else if (margin_trig_reg && i_margin_error) begin
				margin_trig_reg <= 1'b0; // RULE3
			end else if (margin_trig_reg && i_margin_done && !margin_repeat_reg) begin
				margin_trig_reg <= 1'b0; // RULE2
			end
			if (i_access_code) begin
				bidir_reg <= 1'b1; // RULE5
			end else if (i_reg_wr && i_reg_addr == `SFFR_OFS_PINCOMM) begin
				bidir_reg <= i_reg_wdata[`SFFR_BIDIR_EN_BIT]; // RULE5
			end
			if (i_reg_wr && i_reg_addr == `SFFR_OFS_SUPPLY && i_reg_wdata[`SFFR_SUPPLY_TRIG_BIT]) begin
				supply_trig_reg <= 1'b1; // RULE6
				supply_active_reg <= 1'b1; // RULE7
				supply_fail_reg <= 1'b0;
			end else if (supply_active_reg && i_supply_check_done) begin
				supply_trig_reg <= 1'b0;
				supply_active_reg <= 1'b0; // RULE7
				supply_fail_reg <= i_supply_check_fail; // RULE6
			end
			if (i_reg_wr && i_reg_addr == `SFFR_OFS_TRISEL) begin
				tristate_sel_reg <= i_reg_wdata[`SFFR_TRISEL_BIT];
			end
			if (i_reg_wr && i_reg_addr == `SFFR_OFS_RATE) begin
				rate_reg <= i_reg_wdata[`SFFR_RATE_HI:`SFFR_RATE_LO];
			end
			if (i_reg_wr && i_reg_addr == `SFFR_OFS_PORCH) begin
				porch_reg <= i_reg_wdata[`SFFR_PORCH_HI:`SFFR_PORCH_LO]; // RULE21
			end
		end
	end
	// Read data is registered; it appears the cycle after the read strobe.
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata <= 26'h0;
		end else if (i_reg_rd) begin
			o_reg_rdata <= 26'h0;
			case (i_reg_addr)
				`SFFR_OFS_INFO: begin
					o_reg_rdata[`SFFR_INFO_READY_BIT] <= i_angle_sample_ready; // RULE16
					o_reg_rdata[`SFFR_INFO_MASK_BIT] <= |i_fault_mask;
					o_reg_rdata[`SFFR_INFO_SUPPLY_FAIL_BIT] <= supply_fail_reg;
					o_reg_rdata[`SFFR_INFO_CORR_FAIL_BIT] <= i_correction_selftest_failed;
				end
				`SFFR_OFS_FAULT: o_reg_rdata[15:0] <= fault_reg; // RULE8
				`SFFR_OFS_MARGIN: begin
					o_reg_rdata[`SFFR_MARGIN_TRIG_BIT] <= margin_trig_reg;
					o_reg_rdata[`SFFR_MARGIN_REPEAT_BIT] <= margin_repeat_reg;
				end
				`SFFR_OFS_PINCOMM: o_reg_rdata[`SFFR_BIDIR_EN_BIT] <= bidir_reg;
				`SFFR_OFS_SUPPLY: begin
					o_reg_rdata[`SFFR_SUPPLY_TRIG_BIT] <= supply_trig_reg;
					o_reg_rdata[`SFFR_SUPPLY_ACTIVE_BIT] <= supply_active_reg; // RULE7
				end
				`SFFR_OFS_TRISEL: o_reg_rdata[`SFFR_TRISEL_BIT] <= tristate_sel_reg;
				`SFFR_OFS_RATE: o_reg_rdata[`SFFR_RATE_HI:`SFFR_RATE_LO] <= rate_reg;
				`SFFR_OFS_PORCH: o_reg_rdata[`SFFR_PORCH_HI:`SFFR_PORCH_LO] <= porch_reg;
				default: o_reg_rdata <= 26'h0;
			endcase
		end
	end
	assign o_margin_run = margin_trig_reg;
	assign o_supply_check_run = supply_active_reg;
	assign o_bidir_pin_comm_enable = bidir_reg;
	sffr_fault_prio u_prio (
		.i_flags(fault_reg),
		.i_porch_sel(porch_reg),
		.o_any(any_fault),
		.o_top_hiz(top_hiz),
		.o_duty(fault_duty)
	);
	sffr_pwm_out u_pwm (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_stop(bidir_reg),
		.i_fault(any_fault),
		.i_tristate_sel(tristate_sel_reg),
		.i_top_hiz(top_hiz),
		.i_fault_duty(fault_duty),
		.i_angle_duty(i_angle_duty),
		.i_rate(rate_reg),
		.o_pwm(o_pwm),
		.o_pwm_oe(o_pwm_oe)
	);
endmodule // sffr_top

// ### tb/sffr_top_monitor.sv
// Concurrent checks on the ports of the fault flag reporting block.
`timescale 1ns/1ps
module sffr_top_monitor (
	input wire i_clk_sys,
	input wire i_rstn,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire i_reg_spi,
	input wire [7:0] i_reg_addr,
	input wire [25:0] i_reg_wdata,
	input wire i_access_code,
	input wire i_margin_error,
	input wire i_supply_check_done,
	input wire o_margin_run,
	input wire o_supply_check_run,
	input wire o_bidir_pin_comm_enable,
	input wire o_frame_error_bit_zero,
	input wire o_frame_error_bit_one,
	input wire o_pwm_oe
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	wire spi_rd = i_reg_rd && i_reg_spi && i_reg_addr == 8'h0f;
	wire wr_a5 = i_reg_wr && i_reg_addr == 8'ha5;
	wire wr_a9 = i_reg_wr && i_reg_addr == 8'ha9;
	sequence s_margin_start;
		i_reg_wr && i_reg_addr == 8'h85 && i_reg_wdata[0] && !i_margin_error;
	endsequence
	sequence s_margin_fail;
		o_margin_run && i_margin_error && !i_reg_wr;
	endsequence
	a_frame_reset_high: assert property ($rose(i_rstn) |-> o_frame_error_bit_zero && o_frame_error_bit_one)
		else $error("frame bits low after reset");
	a_frame_bits_equal: assert property (o_frame_error_bit_zero == o_frame_error_bit_one)
		else $error("frame bits differ");
	a_frame_clear_read: assert property ($fell(o_frame_error_bit_zero) |-> $past(spi_rd))
		else $error("frame bits cleared without serial read");
	a_margin_start_write: assert property (s_margin_start |=> o_margin_run)
		else $error("margin test not started");
	a_margin_error_stop: assert property (s_margin_fail |=> !o_margin_run)
		else $error("margin test kept running after error");
	a_bidir_stops_pwm: assert property (o_bidir_pin_comm_enable [*3] |-> !o_pwm_oe)
		else $error("output driven in pin communication mode");
	a_access_sets_bidir: assert property (i_access_code |=> o_bidir_pin_comm_enable)
		else $error("access code did not enable pin communication");
	a_bidir_exit_write: assert property (wr_a5 && !i_reg_wdata[15] && !i_access_code |=> !o_bidir_pin_comm_enable)
		else $error("pin communication not left on write of zero");
	a_supply_run_start: assert property (wr_a9 && i_reg_wdata[0] |-> ##[1:2] o_supply_check_run)
		else $error("supply check not running after trigger");
	a_supply_run_stop: assert property (o_supply_check_run && i_supply_check_done && !wr_a9 |=> !o_supply_check_run)
		else $error("supply check still running after done");
endmodule // sffr_top_monitor
bind sffr_top sffr_top_monitor u_monitor (.*);

// ### tb/sffr_host_pin.sv
// Host side model of the output line: resolves the pin and counts driven and high cycles.
`timescale 1ns/1ps
module sffr_host_pin (
	input wire i_clk_sys,
	input wire i_clr,
	input wire i_pwm,
	input wire i_pwm_oe,
	output wire o_pin,
	output logic [15:0] o_drv_cnt,
	output logic [15:0] o_hi_cnt
);
	// The line has a pull-down, so a floating output reads low rather than keeping its last level.
	assign o_pin = i_pwm_oe ? i_pwm : 1'b0;
	always @(posedge i_clk_sys) begin
		o_drv_cnt <= i_clr ? 16'h0000 : o_drv_cnt + {15'h0000, i_pwm_oe};
		o_hi_cnt <= i_clr ? 16'h0000 : o_hi_cnt + {15'h0000, o_pin};
	end
endmodule // sffr_host_pin

// ### tb/tb_top.sv
// Self-checking bench for the fault flag reporting block.
`timescale 1ns/1ps
module tb_top;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_reg_spi = 1'b0, i_sfail = 1'b0, i_rdy = 1'b0, i_corr = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [25:0] i_reg_wdata = 26'h0;
	logic [15:0] i_cond = 16'h0000, i_mask = 16'h0000;
	logic [4:0] pls = 5'h00;
	logic clr = 1'b0;
	wire [25:0] rdata;
	wire mrun, srun, bidir, f0, f1, pwm, oe, pin;
	wire [15:0] drv_cnt, hi_cnt;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	sffr_top i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.i_reg_spi(i_reg_spi), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata),
		.i_access_code(pls[4]), .i_fault_cond(i_cond), .i_fault_mask(i_mask), .i_angle_sample_ready(i_rdy),
		.i_correction_selftest_failed(i_corr), .i_margin_done(pls[0]), .i_margin_error(pls[1]),
		.i_supply_check_done(pls[2]), .i_supply_check_fail(i_sfail), .i_angle_duty(8'h64),
		.o_margin_run(mrun), .o_supply_check_run(srun), .o_bidir_pin_comm_enable(bidir),
		.o_frame_error_bit_zero(f0), .o_frame_error_bit_one(f1), .o_pwm(pwm), .o_pwm_oe(oe));
	sffr_host_pin i_host (.i_clk_sys(i_clk_sys), .i_clr(clr), .i_pwm(pwm), .i_pwm_oe(oe), .o_pin(pin),
		.o_drv_cnt(drv_cnt), .o_hi_cnt(hi_cnt));
	task automatic chk(input string nm, input logic [25:0] seen, input logic [25:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [25:0] d);
		@(negedge i_clk_sys);
		i_reg_wr = 1'b1;
		i_reg_addr = a;
		i_reg_wdata = d;
		@(negedge i_clk_sys);
		i_reg_wr = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic s, input logic [25:0] e);
		@(negedge i_clk_sys);
		i_reg_rd = 1'b1;
		i_reg_spi = s;
		i_reg_addr = a;
		@(negedge i_clk_sys);
		i_reg_rd = 1'b0;
		chk($sformatf("reg %h", a), rdata, e);
	endtask
	task automatic pulse(input logic [4:0] p);
		pls = p;
		tick(1);
		pls = 5'h00;
		tick(1);
	endtask
	// The counters are cleared first so that the window never includes the settling of the previous step.
	task automatic meas(input int n);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(n);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	initial begin
		tick(20);
		i_rstn = 1'b1;
		chk("frame", 26'({f0, f1}), 26'h3);
		rd(8'h0f, 1'b0, 26'h200);
		chk("frame", 26'({f0, f1}), 26'h3);
		rd(8'h0f, 1'b1, 26'h0);
		tick(2);
		chk("frame", 26'({f0, f1}), 26'h0);
		wr(8'h0c, 26'h3ff);
		rd(8'h10, 1'b1, 26'h0);
		i_rdy = 1'b1;
		i_corr = 1'b1;
		i_mask = 16'h0001;
		rd(8'h0c, 1'b1, 26'h241);
		$display("test registers done");
		i_cond = 16'h0101;
		tick(4);
		rd(8'h0f, 1'b1, 26'h101);
		tick(2);
		chk("frame", 26'({f0, f1}), 26'h3);
		i_cond = 16'h0001;
		tick(4);
		rd(8'h0f, 1'b1, 26'h101);
		tick(2);
		chk("frame", 26'({f0, f1}), 26'h0);
		i_cond = 16'h0000;
		tick(4);
		rd(8'h0f, 1'b1, 26'h001);
		rd(8'h0f, 1'b1, 26'h0);
		$display("test sticky flags done");
		wr(8'h85, 26'h1);
		chk("margin run", 26'(mrun), 26'h1);
		pulse(5'h01);
		chk("margin run", 26'(mrun), 26'h0);
		wr(8'h85, 26'h2001);
		pulse(5'h01);
		chk("margin run", 26'(mrun), 26'h1);
		pulse(5'h02);
		chk("margin run", 26'(mrun), 26'h0);
		i_sfail = 1'b1;
		wr(8'ha9, 26'h1);
		chk("supply run", 26'(srun), 26'h1);
		rd(8'ha9, 1'b1, 26'h3);
		pulse(5'h04);
		chk("supply run", 26'(srun), 26'h0);
		rd(8'ha9, 1'b1, 26'h0);
		rd(8'h0c, 1'b1, 26'h2c1);
		$display("test self tests done");
		wr(8'ha5, 26'h8000);
		tick(3);
		chk("pin comm", 26'({bidir, oe}), 26'h2);
		rd(8'ha5, 1'b1, 26'h8000);
		wr(8'ha5, 26'h0);
		chk("pin comm", 26'(bidir), 26'h0);
		pulse(5'h10);
		chk("pin comm", 26'(bidir), 26'h1);
		wr(8'ha5, 26'h0);
		$display("test pin comm done");
		wr(8'h25, 26'h0);
		tick(400);
		meas(400);
		chk("driven", 26'(drv_cnt), 26'd400);
		chk("high share", 26'(hi_cnt > 150 && hi_cnt < 250), 26'h1);
		wr(8'h24, 26'h8000);
		i_cond = 16'h0001;
		tick(4);
		i_cond = 16'h0000;
		tick(4);
		meas(400);
		chk("driven", 26'(drv_cnt), 26'd0);
		rd(8'h0f, 1'b1, 26'h001);
		tick(500);
		meas(200);
		chk("driven", 26'(drv_cnt), 26'd200);
		wr(8'h24, 26'h0);
		i_cond = 16'h0001;
		tick(8);
		meas(400);
		chk("driven", 26'(drv_cnt), 26'd400);
		chk("fault duty", 26'(hi_cnt), 26'd132);
		i_cond = 16'h0008;
		tick(8);
		meas(400);
		chk("driven", 26'(drv_cnt), 26'd0);
		i_cond = 16'h0000;
		tick(4);
		rd(8'h0f, 1'b1, 26'h009);
		rd(8'h0f, 1'b1, 26'h008);
		$display("test output faults done");
		i_rstn = 1'b0;
		tick(2);
		i_rstn = 1'b1;
		chk("frame", 26'({f0, f1}), 26'h3);
		tick(10);
		meas(400);
		chk("fault duty", 26'(hi_cnt), 26'd66);
		wr(8'h3f, 26'h3800);
		rd(8'h3f, 1'b1, 26'h3800);
		tick(10);
		meas(400);
		chk("fault duty", 26'(hi_cnt), 26'd60);
		rd(8'h0f, 1'b1, 26'h200);
		$display("test second reset done");
		test_done();
	end
endmodule // tb_top
